// [hdl/rpc_params.svh]
// Register offsets, field positions, reset values and selections of the radio packet core
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define RPC_OFS_PIN_CFG0 8'h00
`define RPC_OFS_PIN_CFG1 8'h01
`define RPC_OFS_PKT_HIGH 8'h02
`define RPC_OFS_PKT_LOW 8'h03
`define RPC_OFS_PKT_LEN 8'h04
`define RPC_OFS_MODEM2 8'h05
`define RPC_OFS_CAL_RES 8'h06
`define RPC_OFS_VCO_TEST 8'h07
`define RPC_OFS_PKT_STATE 8'h08
`define RPC_OFS_STROBE 8'h09
`define RPC_OFS_RX_DATA 8'h0A
`define RPC_OFS_TX_DATA 8'h0B
`define RPC_OFS_RX_COUNT 8'h0C
`define RPC_OFS_RIN_LVL 8'h0D
`define RPC_OFS_LV_STAT 8'h0E

// ****************************************
// Field positions
// ****************************************
`define RPC_STB_IDLE 0
`define RPC_STB_FLUSH 1
`define RPC_STB_RX 2
`define RPC_STB_TX 3
`define RPC_STB_SLEEP 4
`define RPC_PKTH_APPEND 2
`define RPC_PKTL_CRC 2
`define RPC_LV_FLAG 0
`define RPC_LV_CORE_LSB 1

// ****************************************
// Encodings and reset values
// ****************************************
`define RPC_LEN_VARIABLE 2'h1
`define RPC_LEN_FIXED 2'h0
`define RPC_SEL_RX_PKT 6'h06
`define RPC_SEL_LOCK 6'h0A
`define RPC_CAL_UNLOCKED 6'h3F
`define RPC_CAL_LOCK_ALT 6'h3E
`define RPC_RST_PIN_SEL 6'h00
`define RPC_RST_PKT_LEN 8'hFF
`define RPC_RST_VCO_TEST 8'h00
`define RPC_RST_SYNC_MODE 3'h2
`define RPC_HALF_BYTE_BITS 3'h3
`define RPC_BYTE_LAST_BIT 3'h7
`define RPC_STATUS_BYTES 2'h2

`endif

// [hdl/rpc_pkg.sv]
// Types of the radio packet core
`default_nettype none
package rpc_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_rx,
    st_rx_ovf,
    st_tx,
    st_sleep
  } rpc_state_t;
endpackage : rpc_pkg
`default_nettype wire

// [hdl/rpc_rx_mem.sv]
// Receive FIFO storage with registered read and write bypass
`timescale 1ns/1ps
`default_nettype none
module rpc_rx_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_next;

  always_comb begin
    rdata_next = (we && waddr == raddr) ? wdata : mem[raddr];
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_next;
    end
  end
endmodule : rpc_rx_mem
`default_nettype wire

// [hdl/rpc_core.sv]
// Radio packet core: receive FIFO, status append, transmit bit engine, output pins
//
// Functional notes
// - Receive path has a 64-byte FIFO plus one prefetch byte before it.
// - Byte arriving with FIFO and prefetch both full enters receive-overflow state.
// - Overflow is left only by go-idle strobe, then flush-receive strobe.
// - Pin on selection 0x06 deasserts when the receive FIFO overflows.
// - With append on, two status bytes follow payload; variable mode leads with length.
// - Length mode 1 selects variable length, 0 selects fixed length.
// - Byte-fetch request rises at each byte start, falls after half the byte.
// - With packet handling, transmit ends itself after last bit of last byte.
// - Pin on selection 0x0A carries the synthesizer lock detector.
// - Calibration result reads other than 0x3F whenever synthesizer is locked.
// - VCO calibration test register is lost in sleep; host rewrites it.
// - Packet-end input sets as last byte enters FIFO, clears on first read.
// - With CRC and append both enabled, CRC-pass bit is appended at packet end.
// - Low-voltage error is not raised in sleep or idle at core level 0 or 1.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rpc_params.svh"
module rpc_core #(
  parameter int DEPTH = 64,
  parameter int BIT_DIV = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Demodulated receive bytes and packet status
  input wire logic rx_in_valid,
  input wire logic [7:0] rx_in_data,
  input wire logic [7:0] rssi_in,
  input wire logic [6:0] lqi_in,
  input wire logic crc_ok_in,
  // Synthesizer and supply
  input wire logic synth_lock,
  input wire logic [5:0] synth_cal_in,
  input wire logic low_volt_detect,
  // Modulator
  output logic tx_bit,
  output logic tx_fetch_req,
  // General output pins
  output logic general_output_pin0,
  output logic general_output_pin1
);
  import rpc_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = AW'(DEPTH) == '0 ? {1'b1, {AW{1'b0}}} : (AW+1)'(DEPTH);
  localparam logic [7:0] DIV_LAST = 8'(BIT_DIV - 1);

  // ****************************************
  // State
  // ****************************************
  rpc_state_t state_reg, state_next;
  logic [5:0] pin_sel0_reg, pin_sel0_next, pin_sel1_reg, pin_sel1_next;
  logic append_reg, append_next, crc_en_reg, crc_en_next;
  logic [1:0] len_mode_reg, len_mode_next, core_volt_reg, core_volt_next;
  logic [7:0] pkt_len_reg, pkt_len_next, vco_test_reg, vco_test_next;
  logic [2:0] sync_mode_reg, sync_mode_next;
  logic lv_err_reg, lv_err_next, ovf_reg, ovf_next, rx_end_reg, rx_end_next;
  logic pf_full_reg, pf_full_next, pf_last_reg, pf_last_next;
  logic [7:0] pf_data_reg, pf_data_next;
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic [8:0] rx_cnt_reg, rx_cnt_next, rx_total_reg, rx_total_next;
  logic [1:0] stat_pend_reg, stat_pend_next;
  logic [7:0] tx_hold_reg, tx_hold_next, shift_reg, shift_next, tx_cnt_reg, tx_cnt_next;
  logic [7:0] div_cnt_reg, div_cnt_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic fetch_reg, fetch_next, tx_bit_reg, tx_bit_next;
  logic gpo0_reg, gpo0_next, gpo1_reg, gpo1_next;
  logic [7:0] rdata_reg, rdata_next;
  // Combinational helpers
  logic stb_idle, stb_flush, stb_rx, stb_tx, stb_sleep, push, pop, in_v, in_last;
  logic rx_take, ovf_hit, tick, lv_quiet;
  logic [7:0] in_d, head_data;
  logic [8:0] total;
  logic [5:0] cal_view;

  rpc_rx_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_rx_mem (
    .clk(clk),
    .rst_b(rst_b),
    .we(push),
    .waddr(wr_ptr_reg),
    .wdata(pf_data_reg),
    .raddr(rd_ptr_next),
    .rdata(head_data)
  );

  function automatic logic pin_drive(input logic [5:0] sel, input logic rx_on, input logic lock);
    if (sel == `RPC_SEL_LOCK) return lock;
    else if (sel == `RPC_SEL_RX_PKT) return rx_on;
    else return 1'b0;
  endfunction : pin_drive

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_next = state_reg;
    pin_sel0_next = pin_sel0_reg;
    pin_sel1_next = pin_sel1_reg;
    append_next = append_reg;
    crc_en_next = crc_en_reg;
    len_mode_next = len_mode_reg;
    core_volt_next = core_volt_reg;
    pkt_len_next = pkt_len_reg;
    vco_test_next = vco_test_reg;
    sync_mode_next = sync_mode_reg;
    lv_err_next = lv_err_reg;
    ovf_next = ovf_reg;
    rx_end_next = rx_end_reg;
    pf_full_next = pf_full_reg;
    pf_last_next = pf_last_reg;
    pf_data_next = pf_data_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_total_next = rx_total_reg;
    stat_pend_next = stat_pend_reg;
    tx_hold_next = tx_hold_reg;
    shift_next = shift_reg;
    tx_cnt_next = tx_cnt_reg;
    bit_cnt_next = bit_cnt_reg;
    fetch_next = fetch_reg;
    tx_bit_next = tx_bit_reg;
    div_cnt_next = div_cnt_reg;
    rdata_next = '0;
    stb_idle = reg_wr && reg_addr == `RPC_OFS_STROBE && reg_wdata[`RPC_STB_IDLE];
    stb_flush = reg_wr && reg_addr == `RPC_OFS_STROBE && reg_wdata[`RPC_STB_FLUSH];
    stb_rx = reg_wr && reg_addr == `RPC_OFS_STROBE && reg_wdata[`RPC_STB_RX];
    stb_tx = reg_wr && reg_addr == `RPC_OFS_STROBE && reg_wdata[`RPC_STB_TX];
    stb_sleep = reg_wr && reg_addr == `RPC_OFS_STROBE && reg_wdata[`RPC_STB_SLEEP];
    // Configuration writes
    if (reg_wr) begin
      unique case (reg_addr)
        `RPC_OFS_PIN_CFG0: pin_sel0_next = reg_wdata[5:0];
        `RPC_OFS_PIN_CFG1: pin_sel1_next = reg_wdata[5:0];
        `RPC_OFS_PKT_HIGH: append_next = reg_wdata[`RPC_PKTH_APPEND];
        `RPC_OFS_PKT_LOW: begin
          crc_en_next = reg_wdata[`RPC_PKTL_CRC];
          len_mode_next = reg_wdata[1:0];
        end
        `RPC_OFS_PKT_LEN: pkt_len_next = reg_wdata;
        `RPC_OFS_MODEM2: sync_mode_next = reg_wdata[2:0];
        `RPC_OFS_VCO_TEST: vco_test_next = reg_wdata;
        `RPC_OFS_TX_DATA: tx_hold_next = reg_wdata;
        `RPC_OFS_LV_STAT: core_volt_next = reg_wdata[`RPC_LV_CORE_LSB +: 2];
        default: ;
      endcase
    end
    push = pf_full_reg && count_reg != FULL_CNT;
    pop = reg_rd && reg_addr == `RPC_OFS_RX_DATA && count_reg != '0;
    if (len_mode_reg == `RPC_LEN_VARIABLE && rx_cnt_reg == '0) total = {1'b0, rx_in_data} + 9'h001;
    else if (len_mode_reg == `RPC_LEN_VARIABLE) total = rx_total_reg;
    else total = {1'b0, pkt_len_reg};
    rx_take = state_reg == st_rx && stat_pend_reg == '0 && rx_in_valid;
    in_v = rx_take || (state_reg == st_rx && stat_pend_reg != '0);
    if (stat_pend_reg == `RPC_STATUS_BYTES) in_d = rssi_in;
    else if (stat_pend_reg != '0) in_d = {crc_en_reg & crc_ok_in, lqi_in};
    else in_d = rx_in_data;
    in_last = rx_take ? (!append_reg && rx_cnt_reg + 9'h001 == total) : stat_pend_reg == 2'h1;
    ovf_hit = in_v && pf_full_reg && !push;
    if (push) begin
      wr_ptr_next = wr_ptr_reg + AW'(1);
      pf_full_next = 1'b0;
    end
    if (pop) rd_ptr_next = rd_ptr_reg + AW'(1);
    if (in_v && !ovf_hit) begin
      pf_full_next = 1'b1;
      pf_data_next = in_d;
      pf_last_next = in_last;
      if (rx_take) begin
        rx_cnt_next = rx_cnt_reg + 9'h001;
        rx_total_next = total;
        if (rx_cnt_reg + 9'h001 == total) begin
          rx_cnt_next = '0;
          if (append_reg) stat_pend_next = `RPC_STATUS_BYTES;
          else state_next = st_idle;
        end
      end else begin
        stat_pend_next = stat_pend_reg - 2'h1;
        if (stat_pend_reg == 2'h1) state_next = st_idle;
      end
    end
    if (pop && !rx_end_reg) rx_end_next = rx_end_reg;
    else if (pop) rx_end_next = 1'b0;
    if (push && pf_last_reg) rx_end_next = 1'b1;
    lv_quiet = (state_reg == st_idle || state_reg == st_sleep) && core_volt_reg <= 2'h1;
    if (reg_wr && reg_addr == `RPC_OFS_LV_STAT && reg_wdata[`RPC_LV_FLAG]) lv_err_next = 1'b0;
    if (low_volt_detect && !lv_quiet) lv_err_next = 1'b1;
    // Bit-rate divider
    tick = state_reg == st_tx && div_cnt_reg == DIV_LAST;
    div_cnt_next = (state_reg != st_tx || tick) ? '0 : div_cnt_reg + 8'h01;
    unique case (state_reg)
      st_idle: begin
        if (stb_flush) begin
          wr_ptr_next = '0;
          rd_ptr_next = '0;
          pf_full_next = 1'b0;
          pf_last_next = 1'b0;
          ovf_next = 1'b0;
          rx_end_next = 1'b0;
          stat_pend_next = '0;
        end else if (stb_rx && !ovf_reg) begin
          state_next = st_rx;
          rx_cnt_next = '0;
          stat_pend_next = '0;
        end else if (stb_tx) begin
          state_next = st_tx;
          shift_next = tx_hold_reg;
          tx_bit_next = tx_hold_reg[7];
          fetch_next = 1'b1;
          bit_cnt_next = '0;
          tx_cnt_next = '0;
        end else if (stb_sleep) begin
          state_next = st_sleep;
        end
      end
      st_rx: begin
        if (stb_idle) begin
          state_next = st_idle;
          stat_pend_next = '0;
        end else if (ovf_hit) begin
          state_next = st_rx_ovf;
          ovf_next = 1'b1;
        end
      end
      st_rx_ovf: begin
        if (stb_idle) state_next = st_idle;
      end
      st_tx: begin
        if (stb_idle) begin
          state_next = st_idle;
          fetch_next = 1'b0;
          tx_bit_next = 1'b0;
        end else if (tick) begin
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == `RPC_BYTE_LAST_BIT) begin
            if (sync_mode_reg != '0 && {1'b0, tx_cnt_reg} + 9'h001 == {1'b0, pkt_len_reg}) begin
              state_next = st_idle;
              fetch_next = 1'b0;
              tx_bit_next = 1'b0;
            end else begin
              shift_next = tx_hold_reg;
              tx_bit_next = tx_hold_reg[7];
              fetch_next = 1'b1;
              tx_cnt_next = tx_cnt_reg + 8'h01;
            end
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            tx_bit_next = shift_reg[6];
            if (bit_cnt_reg == `RPC_HALF_BYTE_BITS) fetch_next = 1'b0;
          end
        end
      end
      st_sleep: begin
        vco_test_next = `RPC_RST_VCO_TEST;
        if (stb_idle) state_next = st_idle;
      end
    endcase
    count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    if (state_reg == st_idle && stb_flush) count_next = '0;
    if (!synth_lock) cal_view = `RPC_CAL_UNLOCKED;
    else if (synth_cal_in == `RPC_CAL_UNLOCKED) cal_view = `RPC_CAL_LOCK_ALT;
    else cal_view = synth_cal_in;
    if (reg_rd) begin
      unique case (reg_addr)
        `RPC_OFS_PIN_CFG0: rdata_next = {2'h0, pin_sel0_reg};
        `RPC_OFS_PIN_CFG1: rdata_next = {2'h0, pin_sel1_reg};
        `RPC_OFS_PKT_HIGH: rdata_next = 8'(append_reg) << `RPC_PKTH_APPEND;
        `RPC_OFS_PKT_LOW: rdata_next = {5'h00, crc_en_reg, len_mode_reg};
        `RPC_OFS_PKT_LEN: rdata_next = pkt_len_reg;
        `RPC_OFS_MODEM2: rdata_next = {5'h00, sync_mode_reg};
        `RPC_OFS_CAL_RES: rdata_next = {2'h0, cal_view};
        `RPC_OFS_VCO_TEST: rdata_next = vco_test_reg;
        `RPC_OFS_PKT_STATE: rdata_next = {2'h0, state_reg == st_sleep, state_reg == st_tx,
                                          state_reg == st_rx, ovf_reg, gpo1_reg, gpo0_reg};
        `RPC_OFS_RX_DATA: rdata_next = pop ? head_data : 8'h00;
        `RPC_OFS_RX_COUNT: rdata_next = 8'(count_reg);
        `RPC_OFS_RIN_LVL: rdata_next = {5'h00, ovf_reg, count_reg != '0, rx_end_reg};
        `RPC_OFS_LV_STAT: rdata_next = {5'h00, core_volt_reg, lv_err_reg};
        default: rdata_next = 8'h00;
      endcase
    end
    gpo0_next = pin_drive(pin_sel0_reg, state_next == st_rx, synth_lock);
    gpo1_next = pin_drive(pin_sel1_reg, state_next == st_rx, synth_lock);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= st_idle;
      pin_sel0_reg <= `RPC_RST_PIN_SEL;
      pin_sel1_reg <= `RPC_RST_PIN_SEL;
      append_reg <= 1'b0;
      crc_en_reg <= 1'b0;
      len_mode_reg <= `RPC_LEN_FIXED;
      core_volt_reg <= '0;
      pkt_len_reg <= `RPC_RST_PKT_LEN;
      vco_test_reg <= `RPC_RST_VCO_TEST;
      sync_mode_reg <= `RPC_RST_SYNC_MODE;
      {lv_err_reg, ovf_reg, rx_end_reg, pf_full_reg, pf_last_reg} <= '0;
      pf_data_reg <= '0;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      rx_cnt_reg <= '0;
      rx_total_reg <= '0;
      stat_pend_reg <= '0;
      {tx_hold_reg, shift_reg, tx_cnt_reg, div_cnt_reg} <= '0;
      bit_cnt_reg <= '0;
      {fetch_reg, tx_bit_reg, gpo0_reg, gpo1_reg} <= '0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      pin_sel0_reg <= pin_sel0_next;
      pin_sel1_reg <= pin_sel1_next;
      append_reg <= append_next;
      crc_en_reg <= crc_en_next;
      len_mode_reg <= len_mode_next;
      core_volt_reg <= core_volt_next;
      pkt_len_reg <= pkt_len_next;
      vco_test_reg <= vco_test_next;
      sync_mode_reg <= sync_mode_next;
      {lv_err_reg, ovf_reg, rx_end_reg} <= {lv_err_next, ovf_next, rx_end_next};
      {pf_full_reg, pf_last_reg} <= {pf_full_next, pf_last_next};
      pf_data_reg <= pf_data_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_total_reg <= rx_total_next;
      stat_pend_reg <= stat_pend_next;
      {tx_hold_reg, shift_reg, tx_cnt_reg, div_cnt_reg} <=
        {tx_hold_next, shift_next, tx_cnt_next, div_cnt_next};
      bit_cnt_reg <= bit_cnt_next;
      {fetch_reg, tx_bit_reg, gpo0_reg, gpo1_reg} <= {fetch_next, tx_bit_next, gpo0_next, gpo1_next};
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign tx_bit = tx_bit_reg;
  assign tx_fetch_req = fetch_reg;
  assign general_output_pin0 = gpo0_reg;
  assign general_output_pin1 = gpo1_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_fifo_cap;
    count_reg <= FULL_CNT;
  endproperty
  a_fifo_cap: assert property (p_fifo_cap) else $error("FIFO count above depth");
  property p_ovf_entry;
    state_reg == st_rx && !stb_idle && in_v && pf_full_reg && !push |=> state_reg == st_rx_ovf && ovf_reg;
  endproperty
  a_ovf_entry: assert property (p_ovf_entry) else $error("Overflow not entered");
  property p_ovf_hold;
    state_reg == st_rx_ovf && !stb_idle |=> state_reg == st_rx_ovf;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("Overflow left without idle");
  property p_pin_ovf;
    state_reg == st_rx_ovf && $past(pin_sel0_reg) == `RPC_SEL_RX_PKT |-> !general_output_pin0;
  endproperty
  a_pin_ovf: assert property (p_pin_ovf) else $error("Pin high in overflow");
  property p_fetch_half;
    state_reg == st_tx && tick && !stb_idle && bit_cnt_reg == 3'h3 |=> !tx_fetch_req;
  endproperty
  a_fetch_half: assert property (p_fetch_half) else $error("Fetch not dropped at half");
  property p_tx_abort;
    state_reg == st_tx && stb_idle |=> !tx_fetch_req && state_reg == st_idle;
  endproperty
  a_tx_abort: assert property (p_tx_abort) else $error("Abort left fetch high");
  property p_lock_pin;
    pin_sel1_reg == `RPC_SEL_LOCK && $stable(pin_sel1_reg) |=> general_output_pin1 == $past(synth_lock);
  endproperty
  a_lock_pin: assert property (p_lock_pin) else $error("Lock pin mismatch");
  property p_cal_lock;
    reg_rd && reg_addr == `RPC_OFS_CAL_RES && synth_lock |=> reg_rdata[5:0] != `RPC_CAL_UNLOCKED;
  endproperty
  a_cal_lock: assert property (p_cal_lock) else $error("Locked but reads 0x3F");
  property p_vco_sleep;
    state_reg == st_sleep |=> vco_test_reg == `RPC_RST_VCO_TEST;
  endproperty
  a_vco_sleep: assert property (p_vco_sleep) else $error("Test register kept in sleep");
  property p_lv_quiet;
    !lv_err_reg && lv_quiet |=> !lv_err_reg;
  endproperty
  a_lv_quiet: assert property (p_lv_quiet) else $error("Low-voltage flag in quiet state");
  property p_end_set;
    push && pf_last_reg |=> rx_end_reg;
  endproperty
  a_end_set: assert property (p_end_set) else $error("Packet end not set");

  c_overflow: cover property (state_reg == st_rx ##1 state_reg == st_rx_ovf);
  c_tx_done: cover property (state_reg == st_tx && sync_mode_reg != '0 ##1 state_reg == st_idle);
  c_status: cover property (stat_pend_reg == 2'h1 && in_v ##1 state_reg == st_idle);
endmodule : rpc_core
`default_nettype wire

// [sim/rpc_radio_model.sv]
// Demodulated byte source standing in for the radio front end
`timescale 1ns/1ps
`default_nettype none
module rpc_radio_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Burst control
  input wire logic start,
  input wire logic [7:0] base,
  input wire logic [7:0] num,
  // Byte stream
  output logic rx_in_valid,
  output logic [7:0] rx_in_data
);
  // ****************************************
  // Burst of counting bytes, one every two cycles
  // ****************************************
  logic [7:0] left_reg;
  logic [7:0] cur_reg;
  logic ph_reg;
  // Data toggles while not valid
  assign rx_in_data = rx_in_valid ? cur_reg : ~cur_reg;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      left_reg <= 8'h00;
      cur_reg <= 8'h00;
      ph_reg <= 1'b0;
      rx_in_valid <= 1'b0;
    end else if (start) begin
      left_reg <= num;
      cur_reg <= base;
    end else begin
      ph_reg <= !ph_reg;
      rx_in_valid <= (left_reg != 8'h00) && !ph_reg;
      if (rx_in_valid) begin
        cur_reg <= cur_reg + 8'h01;
        left_reg <= left_reg - 8'h01;
      end
    end
  end
endmodule : rpc_radio_model
`default_nettype wire

// [sim/radio_packet_core_test.sv]
// Register-level testbench of the radio packet core
`timescale 1ns/1ps
`default_nettype none
`include "rpc_params.svh"
module radio_packet_core_test;
  // ****************************************
  // Signals, clock, instances
  // ****************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic go = 1'b0;
  logic lock = 1'b0;
  logic lvd = 1'b0;
  logic crc = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] base = 8'h00;
  logic [7:0] num = 8'h00;
  logic [5:0] cal = 6'h00;
  logic [7:0] rdat, v, rxd;
  logic rxv, txb, fetch, pin0, pin1;
  int fails = 0;
  int checked = 0;
  int m, k, i, n;
  always #4 clk = ~clk;
  rpc_core #(.DEPTH(64), .BIT_DIV(4)) rpc_core_i (.clk(clk), .rst_b(rst_b),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat),
    .rx_in_valid(rxv), .rx_in_data(rxd), .rssi_in(8'h55), .lqi_in(7'h12),
    .crc_ok_in(crc), .synth_lock(lock), .synth_cal_in(cal), .low_volt_detect(lvd),
    .tx_bit(txb), .tx_fetch_req(fetch), .general_output_pin0(pin0),
    .general_output_pin1(pin1));
  rpc_radio_model rpc_radio_model_i (.clk(clk), .rst_b(rst_b), .start(go),
    .base(base), .num(num), .rx_in_valid(rxv), .rx_in_data(rxd));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm,
                    input logic [7:0] mk = 8'hFF);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = reg_mask(rdat, mk);
    chk(nm, v, e);
  endtask : rc
  function automatic logic [7:0] reg_mask(input logic [7:0] x, input logic [7:0] mk);
    return x & mk;
  endfunction : reg_mask
  task automatic send(input logic [7:0] b, input logic [7:0] c);
    @(posedge clk);
    base <= b;
    num <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : send
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rc(`RPC_OFS_PKT_LEN, 8'hFF, "len");
    rc(`RPC_OFS_MODEM2, 8'h02, "sync");
    rc(8'hF0, 8'h00, "unmapped");
    wr(`RPC_OFS_PKT_HIGH, 8'h04);
    wr(`RPC_OFS_PKT_LEN, 8'h04); // length fits FIFO
    for (m = 0; m < 2; m++) begin
      crc <= (m == 0);
      wr(`RPC_OFS_PKT_LOW, 8'h04 | m[7:0]);
      wr(`RPC_OFS_STROBE, 8'h04);
      send(8'h02, 8'h05);
      cyc(30);
      n = (m == 1) ? 3 : 4;
      rc(`RPC_OFS_RX_COUNT, 8'(n + 2), "count");
      rc(`RPC_OFS_RIN_LVL, 8'h01, "end set", 8'h01);
      for (i = 0; i < n; i++) begin // host reads payload bytes from FIFO
        rc(`RPC_OFS_RX_DATA, 8'(i + 2), "payload");
        if (i == 0) rc(`RPC_OFS_RIN_LVL, 8'h00, "end clr", 8'h01);
      end
      rc(`RPC_OFS_RX_DATA, 8'h55, "rssi");
      rc(`RPC_OFS_RX_DATA, (m == 0) ? 8'h92 : 8'h12, "crc lqi");
    end
    wr(`RPC_OFS_PIN_CFG0, 8'h06);
    wr(`RPC_OFS_PKT_LEN, 8'hFF);
    for (k = 0; k < 4; k++) begin
      wr(`RPC_OFS_PKT_HIGH, {5'h00, k[0], 2'h0});
      wr(`RPC_OFS_PKT_LOW, {5'h00, k[1], 2'h0});
      wr(`RPC_OFS_STROBE, 8'h04);
      cyc(1);
      chk("rx pin", {7'h00, pin0}, 8'h01);
      send(8'h00, 8'h41);
      cyc(140);
      rc(`RPC_OFS_PKT_STATE, 8'h08, "full no ovf", 8'h0C);
      send(8'h41, 8'h05);
      cyc(20);
      rc(`RPC_OFS_RX_COUNT, 8'h40, "fill");
      rc(`RPC_OFS_PKT_STATE, 8'h04, "ovf", 8'h0C);
      chk("ovf pin", {7'h00, pin0}, 8'h00);
      wr(`RPC_OFS_STROBE, 8'h04);
      rc(`RPC_OFS_PKT_STATE, 8'h04, "stuck", 8'h0C);
      wr(`RPC_OFS_STROBE, 8'h01);
      wr(`RPC_OFS_STROBE, 8'h02);
      rc(`RPC_OFS_RX_COUNT, 8'h00, "flushed");
      rc(`RPC_OFS_PKT_STATE, 8'h00, "exit", 8'h0C);
    end
    wr(`RPC_OFS_PIN_CFG1, 8'h0A);
    cyc(3);
    chk("unlock pin", {7'h00, pin1}, 8'h00);
    lock <= 1'b1;
    cal <= 6'h3F;
    cyc(3);
    chk("lock pin", {7'h00, pin1}, 8'h01);
    rc(`RPC_OFS_CAL_RES, 8'h3E, "cal");
    wr(`RPC_OFS_TX_DATA, 8'hA5);
    wr(`RPC_OFS_PKT_LEN, 8'h01);
    wr(`RPC_OFS_STROBE, 8'h08);
    #1 chk("fetch", {7'h00, fetch}, 8'h01);
    chk("msb", {7'h00, txb}, 8'h01);
    cyc(13);
    chk("fetch half", {6'h00, fetch, txb}, 8'h02);
    cyc(4);
    chk("fetch low", {7'h00, fetch}, 8'h00);
    rc(`RPC_OFS_PKT_STATE, 8'h10, "in tx", 8'h10);
    cyc(17);
    rc(`RPC_OFS_PKT_STATE, 8'h00, "tx end", 8'h10);
    wr(`RPC_OFS_STROBE, 8'h08);
    wr(`RPC_OFS_STROBE, 8'h01);
    #1 chk("abort", {7'h00, fetch}, 8'h00);
    wr(`RPC_OFS_STROBE, 8'h08);
    #1 chk("fresh", {6'h00, fetch, txb}, 8'h03);
    wr(`RPC_OFS_STROBE, 8'h01);
    wr(`RPC_OFS_MODEM2, 8'h00);
    wr(`RPC_OFS_STROBE, 8'h08);
    cyc(47);
    rc(`RPC_OFS_PKT_STATE, 8'h10, "no self exit", 8'h10);
    wr(`RPC_OFS_STROBE, 8'h01); // idle after 12 dummy bits
    #1 chk("manual end", {6'h00, fetch, txb}, 8'h00);
    rc(`RPC_OFS_PKT_STATE, 8'h00, "manual idle", 8'h10);
    for (k = 0; k < 3; k++) begin
      wr(`RPC_OFS_LV_STAT, {5'h00, k[1:0], 1'b0});
      lvd <= 1'b1;
      cyc(3);
      lvd <= 1'b0;
      rc(`RPC_OFS_LV_STAT, {5'h00, k[1:0], k == 2}, "lv");
    end
    wr(`RPC_OFS_LV_STAT, 8'h01);
    rc(`RPC_OFS_LV_STAT, 8'h00, "lv clear");
    wr(`RPC_OFS_VCO_TEST, 8'h5A);
    rc(`RPC_OFS_VCO_TEST, 8'h5A, "vco");
    wr(`RPC_OFS_STROBE, 8'h10);
    rc(`RPC_OFS_VCO_TEST, 8'h00, "vco sleep");
    wr(`RPC_OFS_STROBE, 8'h01); // lock pin not watched while waking
    wr(`RPC_OFS_VCO_TEST, 8'h5A); // host rewrites after sleep
    rc(`RPC_OFS_VCO_TEST, 8'h5A, "vco rewrite");
    tally_and_finish();
  end
endmodule : radio_packet_core_test
`default_nettype wire
